// file: duc_pkg.sv
// Shared constants and carriers for one channel of the dual serial transceiver
package duc_pkg;

  // ==========================================================
  // Register map, 4-bit word index on the register port
  typedef logic [3:0] duc_addr_t;
  localparam duc_addr_t OFS_DATA  = 4'h0;  // Holding regs, or divisor low when selected
  localparam duc_addr_t OFS_IER   = 4'h1;  // Interrupt enable, or divisor high
  localparam duc_addr_t OFS_ISR   = 4'h2;
  localparam duc_addr_t OFS_LCR   = 4'h3;
  localparam duc_addr_t OFS_MCR   = 4'h4;
  localparam duc_addr_t OFS_LSR   = 4'h5;
  localparam duc_addr_t OFS_MSR   = 4'h6;
  localparam duc_addr_t OFS_SPR   = 4'h7;
  localparam duc_addr_t OFS_EVT   = 4'h8;  // Sticky events, write one to clear
  localparam duc_addr_t OFS_EMASK = 4'h9;  // Event mask

  // ==========================================================
  // Field positions
  localparam int LCR_DIVISOR_ACCESS_SELECT  = 7;
  localparam int LCR_BREAK = 6;
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_OP1   = 2;
  localparam int MCR_OP2   = 3;
  localparam int MCR_LOOP  = 4;
  localparam int IER_RX    = 0;
  localparam int IER_THR   = 1;
  localparam int IER_LINE  = 2;
  localparam int IER_MDM   = 3;
  localparam int LSR_DR    = 0;
  localparam int LSR_THRE  = 5;
  localparam int LSR_TEMT  = 6;
  localparam int EVT_MDM   = 0;
  localparam int EVT_THRE  = 1;

  // ==========================================================
  // Reset values, write masks, codes
  localparam logic [7:0]  IER_RST   = 8'h00;
  localparam logic [7:0]  LCR_RST   = 8'h00;
  localparam logic [7:0]  MCR_RST   = 8'h00;
  localparam logic [7:0]  SPR_RST   = 8'h00;
  localparam logic [7:0]  ISR_IDLE  = 8'h01;
  localparam logic [7:0]  IER_WMASK = 8'h0F;
  localparam logic [7:0]  MCR_WMASK = 8'h1F;
  localparam logic [15:0] DIV_RST   = 16'h0000;
  localparam logic [1:0]  ISR_LINE  = 2'h3;
  localparam logic [1:0]  ISR_RX    = 2'h2;
  localparam logic [1:0]  ISR_THR   = 2'h1;
  localparam logic [1:0]  ISR_MDM   = 2'h0;
  localparam logic [7:0]  CHAR_TICKS = 8'hA0;  // 10 bits of 16 ticks each

  typedef struct packed {
    logic carrier_detect_in_n;
    logic ring_indicator_in_n;
    logic data_set_ready_in_n;
    logic clear_to_send_in_n;
  } duc_modem_in_s;

  typedef struct packed {
    logic serial_data_out;
    logic user_output_one_pin_n;
    logic user_output_two_pin_n;
    logic request_to_send_pin_n;
    logic terminal_ready_pin_n;
  } duc_pins_s;

  localparam duc_pins_s PINS_RST = 5'h1F;

endpackage

// file: duc_channel.sv
// One channel of the dual serial transceiver: register set, baud generator, modem lines
// Contract
// - Status bit 6: inverted ring, loopback user_output_one
// - Status bit 7: inverted carrier, loopback user_output_two
// - Eight-bit scratch byte, read back, no effect
// - Divide clock by divisor for 16x tick
// - Reset clears enable, line, modem control; id 0x01
// - Reset line status: bits 5,6 set, others clear
// - Reset clears change bits; upper bits follow inputs
// - Reset drives data out and control pins high
// - Divisor select bit redirects offsets 0,1 to divisor
// - Input change sets delta; status read clears all; ring sets its delta only on the trailing edge
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module duc_channel
  import duc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire duc_addr_t     addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  input  wire duc_modem_in_s modem_in,
  output logic [7:0]         rdata_q,
  output duc_pins_s          pins_q,
  output logic               baud_tick_q,
  output logic               irq_q
);

  // ==========================================================
  // State
  logic [7:0]  ier_q;
  logic [7:0]  lcr_q;
  logic [7:0]  mcr_q;
  logic [7:0]  spr_q;
  logic [15:0] div_q;
  logic [15:0] cnt_q;
  logic [3:0]  delta_q;
  logic [3:0]  prev_q;
  logic        prev_ok_q;
  logic        thre_q;
  logic        temt_q;
  logic [7:0]  chr_q;
  logic [1:0]  evt_q;
  logic [1:0]  emask_q;

  function automatic logic [7:0] isr_byte(input logic [7:0] interrupt_enable, input logic [7:0] line_status,
                                          input logic [3:0] dlt);
    if (interrupt_enable[IER_LINE] && |line_status[4:1])
      return {5'h00, ISR_LINE, 1'b0};
    else if (interrupt_enable[IER_RX] && line_status[LSR_DR])
      return {5'h00, ISR_RX, 1'b0};
    else if (interrupt_enable[IER_THR] && line_status[LSR_THRE])
      return {5'h00, ISR_THR, 1'b0};
    else if (interrupt_enable[IER_MDM] && |dlt)
      return {5'h00, ISR_MDM, 1'b0};
    else
      return ISR_IDLE;
  endfunction

  // ==========================================================
  // Decode
  wire        divisor_access_select      = lcr_q[LCR_DIVISOR_ACCESS_SELECT];
  wire        loop      = mcr_q[MCR_LOOP];
  wire        at_data   = addr == OFS_DATA;
  wire        at_ier    = addr == OFS_IER;
  wire        wr_thr    = wr_en && at_data && !divisor_access_select;
  wire        wr_dll    = wr_en && at_data && divisor_access_select;
  wire        wr_dlm    = wr_en && at_ier && divisor_access_select;
  wire        wr_ier    = wr_en && at_ier && !divisor_access_select;
  wire        wr_lcr    = wr_en && addr == OFS_LCR;
  wire        wr_mcr    = wr_en && addr == OFS_MCR;
  wire        wr_spr    = wr_en && addr == OFS_SPR;
  wire        wr_evt    = wr_en && addr == OFS_EVT;
  wire        wr_emask  = wr_en && addr == OFS_EMASK;
  wire        rd_msr    = rd_en && addr == OFS_MSR;

  // ==========================================================
  // Modem status
  // Loopback wiring: bit4 RTS, bit5 DTR, bit6 OP1, bit7 OP2
  wire  [3:0] msr_loop  = {mcr_q[MCR_OP2], mcr_q[MCR_OP1], mcr_q[MCR_DTR], mcr_q[MCR_RTS]};
  wire  [3:0] msr_pins  = ~{modem_in.carrier_detect_in_n, modem_in.ring_indicator_in_n,
                            modem_in.data_set_ready_in_n, modem_in.clear_to_send_in_n};
  wire  [3:0] msr_hi    = loop ? msr_loop : msr_pins;
  // Ring flags only its trailing edge, the others any change
  wire  [3:0] delta_set = prev_ok_q ? {msr_hi[3] ^ prev_q[3], prev_q[2] & ~msr_hi[2],
                                       msr_hi[1:0] ^ prev_q[1:0]} : 4'h0;
  // Set wins over the clear of a simultaneous read
  wire  [3:0] delta_d   = (rd_msr ? 4'h0 : delta_q) | delta_set;

  // ==========================================================
  // Baud generator
  wire        tick      = cnt_q == 16'h0001;
  wire        reload    = cnt_q <= 16'h0001;
  // Divisor sampled only at reload; zero stops the ticks
  wire [15:0] cnt_d     = reload ? div_q : cnt_q - 16'h0001;

  // ==========================================================
  // Transmit status; bit framing lives outside this block
  wire        thre_set  = tick && !thre_q && !wr_thr;
  wire        temt_set  = tick && thre_q && chr_q == 8'h01;
  wire  [7:0] line_status       = {1'b0, temt_q, thre_q, 5'h00};
  wire  [7:0] modem_status       = {msr_hi, delta_q};
  wire  [1:0] evt_set   = {thre_set, |delta_set};
  wire  [1:0] evt_clr   = wr_evt ? wdata[1:0] : 2'h0;
  wire  [1:0] evt_d     = (evt_q & ~evt_clr) | evt_set;

  // ==========================================================
  // Read mux; receiver not present, so its holding reads zero
  wire  [7:0] rd_mux =
      (at_data && divisor_access_select)     ? div_q[7:0] :
      (at_ier && divisor_access_select)      ? div_q[15:8] :
      at_ier                ? ier_q :
      (addr == OFS_ISR)     ? isr_byte(ier_q, line_status, delta_q) :
      (addr == OFS_LCR)     ? lcr_q :
      (addr == OFS_MCR)     ? mcr_q :
      (addr == OFS_LSR)     ? line_status :
      (addr == OFS_MSR)     ? modem_status :
      (addr == OFS_SPR)     ? spr_q :
      (addr == OFS_EVT)     ? {6'h00, evt_q} :
      (addr == OFS_EMASK)   ? {6'h00, emask_q} : 8'h00;

  // Break holds the line low; loopback parks everything inactive
  duc_pins_s pins_d;
  assign pins_d.serial_data_out       = loop || !lcr_q[LCR_BREAK];
  assign pins_d.user_output_one_pin_n = loop || !mcr_q[MCR_OP1];
  assign pins_d.user_output_two_pin_n = loop || !mcr_q[MCR_OP2];
  assign pins_d.request_to_send_pin_n = loop || !mcr_q[MCR_RTS];
  assign pins_d.terminal_ready_pin_n  = loop || !mcr_q[MCR_DTR];

  // ==========================================================
  // Control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ier_q <= IER_RST;
      lcr_q <= LCR_RST;
      mcr_q <= MCR_RST;
      spr_q <= SPR_RST;
      div_q <= DIV_RST;
    end else begin
      if (wr_ier) ier_q <= wdata & IER_WMASK;
      if (wr_lcr) lcr_q <= wdata;
      if (wr_mcr) mcr_q <= wdata & MCR_WMASK;
      if (wr_spr) spr_q <= wdata;
      if (wr_dll) div_q[7:0] <= wdata;
      if (wr_dlm) div_q[15:8] <= wdata;
    end
  end

  // Modem change tracking; first cycle after reset only samples
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      delta_q   <= 4'h0;
      prev_q    <= 4'h0;
      prev_ok_q <= 1'b0;
    end else begin
      delta_q   <= delta_d;
      prev_q    <= msr_hi;
      prev_ok_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q       <= 16'h0000;
      baud_tick_q <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      baud_tick_q <= tick;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thre_q <= 1'b1;
      temt_q <= 1'b1;
      chr_q  <= 8'h00;
    end else if (wr_thr) begin
      thre_q <= 1'b0;
      temt_q <= 1'b0;
    end else if (thre_set) begin
      thre_q <= 1'b1;
      chr_q  <= CHAR_TICKS;
    end else if (tick && chr_q != 8'h00) begin
      chr_q  <= chr_q - 8'h01;
      if (temt_set) temt_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_q   <= 2'h0;
      emask_q <= 2'h0;
      irq_q   <= 1'b0;
      rdata_q <= 8'h00;
      pins_q  <= PINS_RST;
    end else begin
      evt_q   <= evt_d;
      if (wr_emask) emask_q <= wdata[1:0];
      irq_q   <= |(evt_d & (wr_emask ? wdata[1:0] : emask_q));
      rdata_q <= rd_en ? rd_mux : 8'h00;
      pins_q  <= pins_d;
    end
  end

  // ==========================================================
  // Checks
  logic [15:0] since_q;
  logic [15:0] last_div_q;
  logic        seen_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_q    <= 16'h0000;
      last_div_q <= 16'h0000;
      seen_q     <= 1'b0;
    end else begin
      since_q <= tick ? 16'h0000 : (&since_q ? since_q : since_q + 16'h0001);
      if (reload) last_div_q <= div_q;
      if (tick) seen_q <= 1'b1;
    end
  end

  AST_RING_MIRROR: assert property (@(posedge clk) disable iff (!arst_n)
    rd_en && addr == OFS_MSR |=> rdata_q[6] ==
      ($past(mcr_q[MCR_LOOP]) ? $past(mcr_q[MCR_OP1]) : !$past(modem_in.ring_indicator_in_n)))
    else $error("modem status bit 6 wrong");
  AST_CARRIER_MIRROR: assert property (@(posedge clk) disable iff (!arst_n)
    rd_en && addr == OFS_MSR |=> rdata_q[7] ==
      ($past(mcr_q[MCR_LOOP]) ? $past(mcr_q[MCR_OP2]) : !$past(modem_in.carrier_detect_in_n)))
    else $error("modem status bit 7 wrong");
  AST_SCRATCH_BACK: assert property (@(posedge clk) disable iff (!arst_n)
    wr_en && addr == OFS_SPR ##1 rd_en && addr == OFS_SPR |=> rdata_q == $past(wdata, 2))
    else $error("scratch byte not read back");
  AST_BAUD_PERIOD: assert property (@(posedge clk) disable iff (!arst_n)
    tick && seen_q |-> since_q + 16'h0001 == last_div_q)
    else $error("baud tick period differs from divisor");
  AST_ISR_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
    rd_en && addr == OFS_ISR && ier_q == 8'h00 |=> rdata_q == ISR_IDLE)
    else $error("identification not idle with interrupts disabled");
  AST_LSR_FIXED: assert property (@(posedge clk) disable iff (!arst_n)
    rd_en && addr == OFS_LSR |=> rdata_q[7] == 1'b0 && rdata_q[4:0] == 5'h00)
    else $error("line status fixed bits wrong");
  AST_DELTA_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    rd_msr && delta_set == 4'h0 |=> delta_q == 4'h0)
    else $error("change bits survive status read");
  AST_DELTA_SET: assert property (@(posedge clk) disable iff (!arst_n)
    prev_ok_q && $changed(msr_hi[0]) |=> delta_q[0])
    else $error("clear-to-send change not flagged");
  AST_RTS_PIN: assert property (@(posedge clk) disable iff (!arst_n)
    !mcr_q[MCR_LOOP] |=> pins_q.request_to_send_pin_n == !$past(mcr_q[MCR_RTS]))
    else $error("request-to-send pin mismatch");
  AST_DIV_REDIRECT: assert property (@(posedge clk) disable iff (!arst_n)
    wr_en && addr == OFS_DATA && lcr_q[LCR_DIVISOR_ACCESS_SELECT] |=> div_q[7:0] == $past(wdata) && $stable(ier_q))
    else $error("divisor select did not redirect write");
  AST_DIV_LATCH: assert property (@(posedge clk) disable iff (!arst_n)
    reload |=> cnt_q == $past(div_q))
    else $error("counter did not reload from divisor");

endmodule

// file: duc_modem_model.sv
// Modem-side partner: drives the four active-low modem status inputs
`timescale 1ns/1ps
module duc_modem_model
  import duc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [3:0] lvl,
  input  wire logic       slow,
  output duc_modem_in_s   modem_in
);
  // ==========================================================
  // Levels
  logic [3:0] stage_q;

  // Slow mode adds a cycle, as a far modem with a line receiver would
  always_ff @(posedge clk) begin
    stage_q  <= lvl;
    modem_in <= duc_modem_in_s'(slow ? stage_q : lvl);
  end
endmodule

// file: duc_channel_bench.sv
// Self-checking bench for one channel: registers, modem lines, pins, baud ticks
`timescale 1ns/1ps
module duc_channel_bench
  import duc_pkg::*;
;
  // ==========================================================
  // Signals
  logic          clk;
  logic          arst_n;
  logic          wr_en;
  logic          rd_en;
  logic          rd_d;
  logic          slow;
  duc_addr_t     addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata_q;
  logic [7:0]    seed;
  logic [3:0]    lvl;
  logic [3:0]    p;
  logic [15:0]   e;
  duc_modem_in_s modem_in;
  duc_pins_s     pins_q;
  logic          baud_tick_q;
  logic          irq_q;
  int            fails;
  int            comparisons;
  int            n;
  int            per;
  logic [15:0]   exp_q[$];

  duc_channel u_duc_channel (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .modem_in(modem_in), .rdata_q(rdata_q), .pins_q(pins_q),
    .baud_tick_q(baud_tick_q), .irq_q(irq_q));
  duc_modem_model u_duc_modem_model (.clk(clk), .lvl(lvl), .slow(slow), .modem_in(modem_in));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wr(input duc_addr_t a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
  endtask

  // Expected value noted with a mask of the bits that are defined
  task automatic rd(input duc_addr_t a, input logic [7:0] x, input logic [7:0] m);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    wr_en <= 1'b0;
    exp_q.push_back({m, x});
  endtask

  task automatic nop(input int c);
    repeat (c) begin
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] x);
    comparisons++;
    if (got !== x) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, x);
    end
  endtask

  // Cycles between two ticks, both waits bounded
  task automatic period(output int c);
    n = 0;
    do begin @(posedge clk); n++; end while (baud_tick_q !== 1'b1 && n < 5000);
    c = 0;
    do begin @(posedge clk); c++; end while (baud_tick_q !== 1'b1 && c < 5000);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Read monitor: data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd_en;
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("Error %0t: read data with nothing expected", $time);
      end else begin
        e = exp_q.pop_front();
        chk(rdata_q & e[15:8], e[7:0] & e[15:8]);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100us;
    fails++;
    final_report();
  end

  // ==========================================================
  // Sequence
  initial begin
    arst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = '0; wdata = '0;
    lvl = 4'h5; slow = 1'b0; seed = 8'hEB; fails = 0; comparisons = 0;
    repeat (10) @(posedge clk);
    chk({3'b000, pins_q}, 8'h1F);
    arst_n <= 1'b1;
    rd(OFS_IER, 8'h00, 8'hFF);
    rd(OFS_ISR, 8'h01, 8'hFF);
    rd(OFS_LCR, 8'h00, 8'hFF);
    rd(OFS_MCR, 8'h00, 8'hFF);
    rd(OFS_LSR, 8'h60, 8'hFF);
    rd(OFS_MSR, 8'hA0, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      p = lvl;
      seed = lfsr(seed);
      lvl <= seed[3:0];
      slow <= seed[4];
      nop(4);
      rd(OFS_MSR, {~seed[3:0], seed[3] ^ p[3], ~p[2] & seed[2], seed[1] ^ p[1],
        seed[0] ^ p[0]}, 8'hFF);
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(OFS_SPR, seed);
      rd(OFS_SPR, seed, 8'hFF);
    end
    // Interrupt: raise, identify, clear, mask
    wr(OFS_EMASK, 8'h01);
    wr(OFS_EVT, 8'h03);
    wr(OFS_IER, 8'hFF);
    rd(OFS_IER, 8'h0F, 8'hFF);
    wr(OFS_IER, 8'h08);
    lvl <= lvl ^ 4'h1;
    nop(4);
    chk({7'h00, irq_q}, 8'h01);
    rd(OFS_ISR, 8'h00, 8'hFF);
    rd(OFS_EVT, 8'h01, 8'h01);
    rd(OFS_MSR, 8'h01, 8'h0F);
    wr(OFS_EVT, 8'h01);
    nop(3);
    chk({7'h00, irq_q}, 8'h00);
    wr(OFS_EMASK, 8'h00);
    lvl <= lvl ^ 4'h8;
    nop(4);
    chk({7'h00, irq_q}, 8'h00);
    wr(OFS_IER, 8'h02);
    rd(OFS_ISR, 8'h02, 8'hFF);
    // Pins and loopback
    wr(OFS_MCR, 8'h0B);
    // Register lands one edge, pin flop the next; look after both
    nop(3);
    chk({3'b000, pins_q}, 8'h18);
    wr(OFS_LCR, 8'h40);
    nop(3);
    chk({3'b000, pins_q}, 8'h08);
    wr(OFS_LCR, 8'h00);
    wr(OFS_MCR, 8'h1C);
    nop(3);
    chk({3'b000, pins_q}, 8'h1F);
    rd(OFS_MSR, 8'hC0, 8'hF0);
    wr(OFS_MCR, 8'h13);
    nop(2);
    rd(OFS_MSR, 8'h30, 8'hF0);
    wr(OFS_MCR, 8'h00);
    wr(4'hA, 8'h55);
    rd(4'hA, 8'h00, 8'hFF);
    // Divisor: redirect and tick period
    wr(OFS_LCR, 8'h80);
    wr(OFS_DATA, 8'h0C);
    wr(OFS_IER, 8'h00);
    rd(OFS_DATA, 8'h0C, 8'hFF);
    wr(OFS_LCR, 8'h03);
    rd(OFS_DATA, 8'h00, 8'hFF);
    rd(OFS_IER, 8'h02, 8'hFF);
    nop(1);
    period(per);
    period(per);
    chk(per[7:0], 8'h0C);
    wr(OFS_LCR, 8'h80);
    wr(OFS_DATA, 8'h03);
    wr(OFS_LCR, 8'h00);
    nop(1);
    period(per);
    period(per);
    chk(per[7:0], 8'h03);
    seed = lfsr(seed);
    wr(OFS_LCR, 8'h80);
    wr(OFS_IER, seed);
    rd(OFS_IER, seed, 8'hFF);
    wr(OFS_LCR, 8'h00);
    rd(OFS_IER, 8'h02, 8'hFF);
    nop(3);
    final_report();
  end
endmodule
